// ---- modem_ctrl.sv ----
/*
  Modem control block: three 8-bit control registers plus the channel clear
  threshold, received frame filtering, channel clear indication, CRC append
  and check, automatic acknowledgment timing, preamble count, correlation gate.
  Assumes an 8-bit external data bus port, frame boundary strobes from the
  radio datapath on mclk, and a signal strength estimate from the receiver.
*/
//
// Operation
// [RULE1] frame type filter alters type, queue untouched
// [RULE2] filtering on, reserved types rejected when bit zero
// [RULE3] reserved types accepted unchecked when bit one
// [RULE4] filtering off accepts every frame
// [RULE5] coordinator role accepts frames lacking destination
// [RULE6] address filter enable bit three, reset one
// [RULE7] three-bit hysteresis, reset two
// [RULE8] mode 01 clear when strength below threshold-hysteresis
// [RULE9] auto checksum appends and checks CRC-16
// [RULE10] unslotted reply twelve symbols after frame
// [RULE11] slotted reply at first boundary beyond twelve
// [RULE12] slotted reply 12-30 symbols, 20-symbol SFD spacing
// [RULE13] preamble bytes equal length field plus one
// [RULE14] software avoids one or two byte preambles
// [RULE15] correlation must reach threshold before SFD search
// [RULE16] gate level selects extended or legacy filtering
// [RULE17] software keeps frame type filter at zero
// [RULE18] signed threshold, reset E0
// [RULE19] settings latched at frame boundaries
`timescale 1ns/10ps
`default_nettype none
module modem_ctrl import mac_ctrl_pkg::*; (
  input wire logic mclk,
  input wire logic rstn,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] channel_clear_threshold_in,
  input wire logic channel_clear_threshold_wr,
  // receive side
  input wire logic rx_sfd,
  input wire logic rx_end,
  input wire logic [2:0] rx_frame_type,
  input wire logic rx_ack_req,
  input wire logic rx_has_dst,
  input wire logic rx_addr_match,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic [7:0] rssi,
  input wire logic [4:0] corr_level,
  input wire logic corr_peak_ok,
  // transmit side
  input wire logic tx_start,
  input wire logic tx_bit_valid,
  input wire logic tx_bit,
  output logic [15:0] tx_crc,
  output logic tx_crc_append,
  output logic [4:0] tx_preamble_bytes,
  // status
  output logic frame_accept,
  output logic crc_ok,
  output logic [2:0] filt_frame_type,
  output logic channel_clear,
  output logic sfd_search_en,
  output logic ack_start
);
  // ==========================================
  // registers
  logic [7:0] mc0h_ff, nxt_mc0h;
  logic [7:0] mc0l_ff, nxt_mc0l;
  logic [7:0] mc1h_ff, nxt_mc1h;
  logic [7:0] thr_ff, nxt_thr;
  logic [7:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_mc0h = mc0h_ff;
    nxt_mc0l = mc0l_ff;
    nxt_mc1h = mc1h_ff;
    nxt_thr = thr_ff;
    nxt_rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_MC0H: nxt_mc0h = reg_wdata;
        ADDR_MC0L: nxt_mc0l = reg_wdata;
        ADDR_MC1H: nxt_mc1h = reg_wdata;
        default: nxt_mc0h = mc0h_ff;
      endcase
    end
    if (channel_clear_threshold_wr) begin
      nxt_thr = channel_clear_threshold_in; // [RULE18]
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_MC0H: nxt_rdata = mc0h_ff;
        ADDR_MC0L: nxt_rdata = mc0l_ff;
        ADDR_MC1H: nxt_rdata = mc1h_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mc0h_ff <= RST_MC0H; // [RULE6] [RULE7]
      mc0l_ff <= RST_MC0L; // [RULE8] [RULE9]
      mc1h_ff <= RST_MC1H; // [RULE15] [RULE16]
      thr_ff <= RST_CHANNEL_CLEAR_THRESHOLD; // [RULE18]
      rdata_ff <= 8'h00;
    end else begin
      mc0h_ff <= nxt_mc0h;
      mc0l_ff <= nxt_mc0l;
      mc1h_ff <= nxt_mc1h;
      thr_ff <= nxt_thr;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ==========================================
  // frame-boundary shadow of settings
  // shadows avoid mixing old and new settings inside one frame
  logic [7:0] rx_cfg_ff, nxt_rx_cfg;
  logic [7:0] rx_cfg0l_ff, nxt_rx_cfg0l;
  logic slot_cfg_ff, nxt_slot_cfg;
  logic [3:0] pre_cfg_ff, nxt_pre_cfg;
  logic tx_crc_en_ff, nxt_tx_crc_en;

  always_comb begin
    nxt_rx_cfg = rx_cfg_ff;
    nxt_rx_cfg0l = rx_cfg0l_ff;
    nxt_slot_cfg = slot_cfg_ff;
    nxt_pre_cfg = pre_cfg_ff;
    nxt_tx_crc_en = tx_crc_en_ff;
    if (rx_sfd) begin // [RULE19]
      nxt_rx_cfg = mc0h_ff;
      nxt_rx_cfg0l = mc0l_ff;
      nxt_slot_cfg = mc1h_ff[SLOT_BIT];
    end
    if (tx_start) begin // [RULE19]
      nxt_pre_cfg = mc0l_ff[PRE_HI:0];
      nxt_tx_crc_en = mc0l_ff[AUTO_CHECKSUM_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_cfg_ff <= RST_MC0H;
      rx_cfg0l_ff <= RST_MC0L;
      slot_cfg_ff <= 1'b0;
      pre_cfg_ff <= RST_MC0L[PRE_HI:0];
      tx_crc_en_ff <= 1'b1;
    end else begin
      rx_cfg_ff <= nxt_rx_cfg;
      rx_cfg0l_ff <= nxt_rx_cfg0l;
      slot_cfg_ff <= nxt_slot_cfg;
      pre_cfg_ff <= nxt_pre_cfg;
      tx_crc_en_ff <= nxt_tx_crc_en;
    end
  end

  // ==========================================
  // frame type manipulation and address filter
  // only the internal view changes; the queued bytes are untouched
  logic [2:0] ftype;
  logic reserved_type;
  logic accept;

  always_comb begin
    ftype = rx_frame_type;
    case (rx_cfg_ff[FT_FILT_HI:FT_FILT_LO]) // [RULE1]
      FT_KEEP: ftype = rx_frame_type;
      FT_INV: ftype = {~rx_frame_type[2], rx_frame_type[1:0]};
      FT_CLR: ftype = {1'b0, rx_frame_type[1:0]};
      default: ftype = {1'b1, rx_frame_type[1:0]};
    endcase
    reserved_type = ftype[2];
    if (!rx_cfg_ff[ADDR_DEC_BIT]) begin
      accept = 1'b1; // [RULE4] [RULE6]
    end else if (reserved_type) begin
      accept = rx_cfg_ff[RES_MODE_BIT]; // [RULE2] [RULE3]
    end else if (!rx_has_dst) begin
      accept = rx_cfg_ff[COORD_BIT]; // [RULE5]
    end else begin
      accept = rx_addr_match;
    end
  end

  // ==========================================
  // checksum units
  logic [15:0] rx_crc;

  crc16_unit u_rx_crc (
    .mclk(mclk),
    .rstn(rstn),
    .clear(rx_sfd),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_bit),
    .crc(rx_crc)
  );

  crc16_unit u_tx_crc (
    .mclk(mclk),
    .rstn(rstn),
    .clear(tx_start),
    .bit_valid(tx_bit_valid),
    .bit_in(tx_bit),
    .crc(tx_crc)
  );

  // residue of zero after the received FCS means a good frame
  logic crc_good;
  assign crc_good = !rx_cfg0l_ff[AUTO_CHECKSUM_BIT] || (rx_crc == 16'h0000); // [RULE9]
  assign tx_crc_append = tx_crc_en_ff; // [RULE9]

  // ==========================================
  // frame result and acknowledgment
  logic accept_ff, nxt_accept;
  logic crc_ok_ff, nxt_crc_ok;
  logic [2:0] ftype_ff, nxt_ftype;
  logic start_ack;

  assign start_ack = rx_end && accept && crc_good && rx_ack_req
                     && rx_cfg0l_ff[AUTO_REPLY_BIT]; // [RULE10]

  always_comb begin
    nxt_accept = accept_ff;
    nxt_crc_ok = crc_ok_ff;
    nxt_ftype = ftype_ff;
    if (rx_end) begin
      nxt_accept = accept;
      nxt_crc_ok = crc_good;
      nxt_ftype = ftype;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      accept_ff <= 1'b0;
      crc_ok_ff <= 1'b0;
      ftype_ff <= 3'h0;
    end else begin
      accept_ff <= nxt_accept;
      crc_ok_ff <= nxt_crc_ok;
      ftype_ff <= nxt_ftype;
    end
  end

  assign frame_accept = accept_ff;
  assign crc_ok = crc_ok_ff;
  assign filt_frame_type = ftype_ff;

  ack_timer u_ack (
    .mclk(mclk),
    .rstn(rstn),
    .sfd(rx_sfd),
    .start(start_ack),
    .slotted(slot_cfg_ff),
    .fire(ack_start)
  );

  // ==========================================
  // preamble, channel clear, correlation gate
  assign tx_preamble_bytes = {1'b0, pre_cfg_ff} + 5'h01; // [RULE13]

  logic [8:0] limit;
  logic clear_ff, nxt_clear;
  logic gate_ff, nxt_gate;

  always_comb begin
    limit = {thr_ff[7], thr_ff} - {6'h00, mc0h_ff[HYST_HI:0]}; // [RULE7]
    nxt_clear = 1'b0;
    if (mc0l_ff[CHANNEL_CLEAR_SELECT_HI:CHANNEL_CLEAR_SELECT_LO] == CCA_SEL_THR) begin
      nxt_clear = $signed({rssi[7], rssi}) < $signed(limit); // [RULE8] [RULE18]
    end
    // legacy gating looks only at the level; extended also needs peak quality
    if (mc1h_ff[GATE_BIT]) begin
      nxt_gate = (corr_level >= mc1h_ff[CTHR_HI:0]) && corr_peak_ok; // [RULE15] [RULE16]
    end else begin
      nxt_gate = corr_level >= mc1h_ff[CTHR_HI:0]; // [RULE15]
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clear_ff <= 1'b0;
      gate_ff <= 1'b0;
    end else begin
      clear_ff <= nxt_clear;
      gate_ff <= nxt_gate;
    end
  end

  assign channel_clear = clear_ff;
  assign sfd_search_en = gate_ff;

  // ==========================================
  // checks
  a_filter_off_all: assert property (@(posedge mclk) disable iff (!rstn)
    (rx_end && !rx_cfg_ff[ADDR_DEC_BIT]) |=> frame_accept)
    else $error("frame dropped with filter off"); // [RULE4]
  a_reserved_reject: assert property (@(posedge mclk) disable iff (!rstn)
    (rx_end && rx_cfg_ff[ADDR_DEC_BIT] && !rx_cfg_ff[RES_MODE_BIT] && ftype[2])
    |=> !frame_accept) else $error("reserved frame accepted"); // [RULE2]
  a_reserved_accept: assert property (@(posedge mclk) disable iff (!rstn)
    (rx_end && rx_cfg_ff[ADDR_DEC_BIT] && rx_cfg_ff[RES_MODE_BIT] && ftype[2])
    |=> frame_accept) else $error("reserved frame rejected"); // [RULE3]
  a_coord_nodst: assert property (@(posedge mclk) disable iff (!rstn)
    (rx_end && rx_cfg_ff[ADDR_DEC_BIT] && !ftype[2] && !rx_has_dst)
    |=> (frame_accept == $past(rx_cfg_ff[COORD_BIT])))
    else $error("no-destination filtering wrong"); // [RULE5]
  a_ftype_inv: assert property (@(posedge mclk) disable iff (!rstn)
    (rx_end && rx_cfg_ff[FT_FILT_HI:FT_FILT_LO] == FT_INV)
    |=> filt_frame_type == {~$past(rx_frame_type[2]), $past(rx_frame_type[1:0])})
    else $error("frame type invert wrong"); // [RULE1]
  a_preamble_cnt: assert property (@(posedge mclk) disable iff (!rstn)
    tx_start |=> tx_preamble_bytes == 5'($past(mc0l_ff[PRE_HI:0])) + 5'h01)
    else $error("preamble count wrong"); // [RULE13]
  a_channel_clear_select_off: assert property (@(posedge mclk) disable iff (!rstn)
    (mc0l_ff[CHANNEL_CLEAR_SELECT_HI:CHANNEL_CLEAR_SELECT_LO] != CCA_SEL_THR) |=> !channel_clear)
    else $error("clear asserted outside mode 01"); // [RULE8]
  a_corr_gate: assert property (@(posedge mclk) disable iff (!rstn)
    (corr_level < mc1h_ff[CTHR_HI:0]) |=> !sfd_search_en)
    else $error("sfd search below threshold"); // [RULE15]
  a_ack_needs_crc: assert property (@(posedge mclk) disable iff (!rstn)
    ack_start |-> (crc_ok && frame_accept))
    else $error("ack started on bad crc"); // [RULE10]
  c_frame_ok: cover property (@(posedge mclk) disable iff (!rstn) rx_end && accept && crc_good);
  c_clear: cover property (@(posedge mclk) disable iff (!rstn) channel_clear);
  c_gate: cover property (@(posedge mclk) disable iff (!rstn) sfd_search_en);
endmodule : modem_ctrl
`default_nettype wire

// ---- mac_ctrl_pkg.sv ----
/*
  Package for the modem control block: register addresses, field positions,
  reset values, mode encodings and timing constants.
  Assumes an 8-bit register port on a 16-bit external data address space.
*/
package mac_ctrl_pkg;
  // ==========================================
  // register map
  localparam logic [15:0] ADDR_MC0H = 16'hDF02;
  localparam logic [15:0] ADDR_MC0L = 16'hDF03;
  localparam logic [15:0] ADDR_MC1H = 16'hDF04;
  localparam logic [7:0] RST_MC0H = 8'h0A;
  localparam logic [7:0] RST_MC0L = 8'hE2;
  localparam logic [7:0] RST_MC1H = 8'h30;
  localparam logic [7:0] RST_CHANNEL_CLEAR_THRESHOLD = 8'hE0;
  // ==========================================
  // field positions
  localparam int FT_FILT_HI = 7;
  localparam int FT_FILT_LO = 6;
  localparam int RES_MODE_BIT = 5;
  localparam int COORD_BIT = 4;
  localparam int ADDR_DEC_BIT = 3;
  localparam int HYST_HI = 2;
  localparam int CHANNEL_CLEAR_SELECT_HI = 7;
  localparam int CHANNEL_CLEAR_SELECT_LO = 6;
  localparam int AUTO_CHECKSUM_BIT = 5;
  localparam int AUTO_REPLY_BIT = 4;
  localparam int PRE_HI = 3;
  localparam int SLOT_BIT = 7;
  localparam int GATE_BIT = 5;
  localparam int CTHR_HI = 4;
  // ==========================================
  // encodings
  localparam logic [1:0] FT_KEEP = 2'h0;
  localparam logic [1:0] FT_INV = 2'h1;
  localparam logic [1:0] FT_CLR = 2'h2;
  localparam logic [1:0] CCA_SEL_THR = 2'h1;
  localparam logic [4:0] LEGACY_CTHR = 5'h14;
  // ==========================================
  // timing: symbol is 16 us
  localparam int CLK_NS = 100;
  localparam int SYMBOL_NS = 16000;
  localparam int SYM_CYC = (SYMBOL_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACK_SYMS = 12;
  localparam int SLOT_SYMS = 20;
  localparam int MAX_SLOT_SYMS = 30;
  localparam logic [7:0] SYM_CYC_M1 = 8'(SYM_CYC - 1);
  localparam logic [5:0] ACK_SYMS_W = 6'(ACK_SYMS);
  localparam logic [5:0] SLOT_SYMS_W = 6'(SLOT_SYMS);
  localparam logic [5:0] MAX_SLOT_W = 6'(MAX_SLOT_SYMS);
  localparam logic [8:0] ZERO_CORR = 9'h000;

  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_WAIT = 2'b01,
    ACK_FIRE = 2'b10
  } ack_state_type;
endpackage : mac_ctrl_pkg

// ---- crc16_unit.sv ----
/*
  Bit-serial CRC-16 (x^16+x^12+x^5+1, LSB first, zero init).
  Assumes the caller presents one bit per clock with bit_valid.
*/
`timescale 1ns/10ps
`default_nettype none
module crc16_unit import mac_ctrl_pkg::*; (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic bit_valid,
  input wire logic bit_in,
  output logic [15:0] crc
);
  logic [15:0] crc_ff;
  logic [15:0] nxt_crc;
  logic fb;

  always_comb begin
    fb = crc_ff[0] ^ bit_in;
    nxt_crc = crc_ff;
    if (clear) begin
      nxt_crc = 16'h0000;
    end else if (bit_valid) begin
      nxt_crc = {1'b0, crc_ff[15:1]};
      if (fb) begin
        nxt_crc = nxt_crc ^ 16'h8408;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      crc_ff <= 16'h0000;
    end else begin
      crc_ff <= nxt_crc;
    end
  end

  assign crc = crc_ff;
endmodule : crc16_unit
`default_nettype wire

// ---- ack_timer.sv ----
/*
  Acknowledgment timer: counts symbol periods from the end of a received
  frame and fires once, unslotted at 12 symbols or at the first 20-symbol
  slot boundary (measured from the received SFD) beyond 12 symbols.
  Assumes start and sfd are one-cycle pulses on mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module ack_timer import mac_ctrl_pkg::*; (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sfd,
  input wire logic start,
  input wire logic slotted,
  output logic fire
);
  ack_state_type state_ff, nxt_state;
  logic [7:0] div_ff, nxt_div;
  logic [7:0] end_div_ff, nxt_end_div;
  logic end_tick;
  logic [5:0] since_end_ff, nxt_since_end;
  logic [5:0] slot_ff, nxt_slot;
  logic tick;
  logic due;

  assign tick = (div_ff == SYM_CYC_M1);
  // the frame end falls at any phase of the sfd-aligned divider, so it gets its own
  assign end_tick = (end_div_ff == SYM_CYC_M1);
  assign due = slotted ? (since_end_ff >= ACK_SYMS_W && slot_ff == SLOT_SYMS_W - 6'h01 && tick)
                       : (since_end_ff == ACK_SYMS_W - 6'h01 && end_tick);
  assign fire = (state_ff == ACK_FIRE);

  always_comb begin
    nxt_state = state_ff;
    nxt_div = tick ? 8'h00 : 8'(div_ff + 8'h01);
    nxt_end_div = end_tick ? 8'h00 : 8'(end_div_ff + 8'h01);
    nxt_since_end = since_end_ff;
    nxt_slot = slot_ff;
    if (sfd) begin
      nxt_div = 8'h00;
      nxt_slot = 6'h00;
    end else if (tick) begin
      nxt_slot = (slot_ff == SLOT_SYMS_W - 6'h01) ? 6'h00 : 6'(slot_ff + 6'h01);
    end
    case (state_ff)
      ACK_IDLE: begin
        if (start) begin
          nxt_state = ACK_WAIT;
          nxt_since_end = 6'h00;
          nxt_end_div = 8'h00;
        end
      end
      ACK_WAIT: begin
        if (end_tick) begin
          nxt_since_end = 6'(since_end_ff + 6'h01);
        end
        // past 30 symbols nothing legal remains; give up
        if (due) begin // [RULE10] [RULE11] [RULE12]
          nxt_state = ACK_FIRE;
        end else if (since_end_ff > MAX_SLOT_W) begin
          nxt_state = ACK_IDLE;
        end
      end
      ACK_FIRE: nxt_state = ACK_IDLE;
      default: nxt_state = ACK_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ACK_IDLE;
      div_ff <= 8'h00;
      end_div_ff <= 8'h00;
      since_end_ff <= 6'h00;
      slot_ff <= 6'h00;
    end else begin
      state_ff <= nxt_state;
      div_ff <= nxt_div;
      end_div_ff <= nxt_end_div;
      since_end_ff <= nxt_since_end;
      slot_ff <= nxt_slot;
    end
  end

  a_ack_single: assert property (@(posedge mclk) disable iff (!rstn)
    fire |=> !fire) else $error("ack fire longer than one cycle"); // [RULE10]
  a_ack_unslot_late: assert property (@(posedge mclk) disable iff (!rstn)
    (fire && !slotted) |-> (since_end_ff == ACK_SYMS_W && end_div_ff == 8'h00))
    else $error("unslotted ack after 12 symbols"); // [RULE10]
  a_ack_slot_edge: assert property (@(posedge mclk) disable iff (!rstn)
    (fire && slotted) |-> (slot_ff == 6'h00 && div_ff == 8'h00))
    else $error("slotted ack off slot boundary"); // [RULE12]
  c_ack_slotted: cover property (@(posedge mclk) disable iff (!rstn) fire && slotted);
  c_ack_plain: cover property (@(posedge mclk) disable iff (!rstn) fire && !slotted);
endmodule : ack_timer
`default_nettype wire

// ---- radio_peer.sv ----
/*
  Far radio node model: sends frames into the receive side of the block.
  Assumes mclk from the bench; it changes its lines 1 ns after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module radio_peer (
  input wire logic mclk,
  output logic rx_sfd,
  output logic rx_end,
  output logic [2:0] rx_frame_type,
  output logic rx_ack_req,
  output logic rx_has_dst,
  output logic rx_addr_match,
  output logic rx_bit_valid,
  output logic rx_bit
);
  integer seed = 88046;
  initial {rx_sfd, rx_end, rx_frame_type, rx_ack_req, rx_has_dst, rx_addr_match, rx_bit_valid, rx_bit} = 10'h000;
  // ==========================================
  // frame sender
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // payload LSB first, then the FCS low byte first; a bad frame flips one FCS bit
  task automatic send(input int nb, input bit good, input logic [5:0] fld, input int pace,
                      output longint ts, output longint te);
    logic [15:0] c;
    logic [7:0] b;
    logic bt;
    int i;
    c = 16'h0000;
    tick(1);
    rx_sfd = 1'b1;
    ts = $time;
    tick(1);
    rx_sfd = 1'b0;
    for (i = 0; i < nb * 8 + 16; i++) begin
      if (i % 8 == 0 && i < nb * 8) b = 8'($random(seed));
      if (i == nb * 8) c[0] = c[0] ^ !good;
      bt = (i < nb * 8) ? b[i % 8] : c[i - nb * 8];
      if (i < nb * 8) c = (c >> 1) ^ ((c[0] ^ bt) ? 16'h8408 : 16'h0000);
      rx_bit = bt;
      rx_bit_valid = 1'b1;
      tick(1);
      rx_bit_valid = 1'b0;
      // released line shows the inverse, not a stale copy
      rx_bit = ~bt;
      if (pace > 1) tick(pace - 1);
    end
    {rx_frame_type, rx_ack_req, rx_has_dst, rx_addr_match} = fld;
    rx_end = 1'b1;
    te = $time;
    tick(1);
    rx_end = 1'b0;
  endtask : send
endmodule : radio_peer
`default_nettype wire

// ---- testbench.sv ----
/*
  Self-checking bench for the modem control block: drivers note expected
  results in a queue, a monitor compares them as results appear.
  Assumes the radio_peer model for the receive side; transmit bits from the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench import mac_ctrl_pkg::*; ();
  typedef struct {int k; logic [31:0] v; logic [31:0] m;} note_type;
  note_type q[$];
  logic mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, channel_clear_threshold_wr = 0, tx_start = 0, corr_peak_ok = 0;
  logic tx_bit_valid = 0, tx_bit = 0;
  logic rd_d = 0, end_d = 0, probe = 0, probe_d = 0;
  logic [15:0] reg_addr = 16'h0000, c;
  logic [7:0] reg_wdata = 8'h00, channel_clear_threshold_in = 8'h00, rssi = 8'h00, v, f, t;
  logic [7:0] h0 = RST_MC0H, l0 = RST_MC0L, h1 = RST_MC1H;
  logic [4:0] corr_level = 5'h00;
  wire rx_sfd, rx_end, rx_ack_req, rx_has_dst, rx_addr_match, rx_bit_valid, rx_bit;
  wire tx_crc_append, frame_accept, crc_ok, channel_clear, sfd_search_en, ack_start;
  wire [2:0] rx_frame_type, filt_frame_type;
  wire [15:0] tx_crc;
  wire [7:0] reg_rdata;
  wire [4:0] tx_preamble_bytes;
  integer num_errors = 0, num_checks = 0, seed = 88046, probe_k = 0, i;

  always #50 mclk = ~mclk;

  modem_ctrl u_dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .channel_clear_threshold_in(channel_clear_threshold_in), .channel_clear_threshold_wr(channel_clear_threshold_wr),
    .rx_sfd(rx_sfd), .rx_end(rx_end), .rx_frame_type(rx_frame_type), .rx_ack_req(rx_ack_req),
    .rx_has_dst(rx_has_dst), .rx_addr_match(rx_addr_match), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .rssi(rssi), .corr_level(corr_level), .corr_peak_ok(corr_peak_ok), .tx_start(tx_start),
    .tx_bit_valid(tx_bit_valid), .tx_bit(tx_bit), .tx_crc(tx_crc), .tx_crc_append(tx_crc_append),
    .tx_preamble_bytes(tx_preamble_bytes), .frame_accept(frame_accept), .crc_ok(crc_ok),
    .filt_frame_type(filt_frame_type), .channel_clear(channel_clear), .sfd_search_en(sfd_search_en),
    .ack_start(ack_start));

  radio_peer u_peer (.mclk(mclk), .rx_sfd(rx_sfd), .rx_end(rx_end), .rx_frame_type(rx_frame_type),
    .rx_ack_req(rx_ack_req), .rx_has_dst(rx_has_dst), .rx_addr_match(rx_addr_match),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));

  // ==========================================
  // monitor
  task automatic err(input string s);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, s);
  endtask : err
  function automatic logic [31:0] act(input int k);
    case (k)
      0: act = 32'(reg_rdata);
      1: act = 32'({frame_accept, crc_ok, filt_frame_type});
      3: act = 32'(channel_clear);
      4: act = 32'(sfd_search_en);
      5: act = 32'({tx_crc_append, tx_preamble_bytes});
      6: act = 32'(tx_crc);
      default: act = 32'($time);
    endcase
  endfunction : act
  task automatic check(input int k);
    note_type n;
    num_checks++;
    if (q.size() == 0 || q[0].k != k) begin
      err($sformatf("unexpected result of kind %0d", k));
      return;
    end
    n = q.pop_front();
    if (k == 2 ? !(act(2) >= n.v && act(2) <= n.v + 200) : (act(k) & n.m) !== (n.v & n.m))
      err($sformatf("kind %0d got %0h expected %0h", k, act(k), n.v));
  endtask : check
  always @(posedge mclk) begin
    rd_d <= reg_rd;
    end_d <= rx_end;
    probe_d <= probe;
  end
  always @(negedge mclk) if (rstn) begin
    if (rd_d) check(0);
    if (end_d) check(1);
    if (ack_start === 1'b1) check(2);
    if (probe_d) check(probe_k);
  end

  // ==========================================
  // drivers
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic note(input int k, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{k, e, m});
  endtask : note
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    if (a == ADDR_MC0H) h0 = d;
    if (a == ADDR_MC0L) l0 = d;
    if (a == ADDR_MC1H) h1 = d;
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    note(0, 32'(e), 32'hFF);
    {reg_addr, reg_rd} = {a, 1'b1};
    tick(1);
    reg_rd = 1'b0;
    tick(1);
  endtask : rd
  task automatic prb(input int k, input logic [31:0] e);
    note(k, e, 32'hFFFF);
    {probe_k, probe} = {k, 1'b1};
    tick(1);
    probe = 1'b0;
    tick(1);
  endtask : prb
  // expectation taken from the settings in force when the frame starts
  task automatic frm(input int nb, input bit good, input logic [2:0] ft, input logic ar, ds, mt,
                     input int pace, input logic [31:0] m);
    logic [2:0] tp;
    logic acc;
    longint ts, te, k;
    case (h0[7:6])
      2'h0: tp = ft;
      2'h1: tp = {~ft[2], ft[1:0]};
      2'h2: tp = {1'b0, ft[1:0]};
      default: tp = {1'b1, ft[1:0]};
    endcase
    if (tp != 3'h1 && tp != 3'h3) ds = 1'b1;
    if (!ds) mt = 1'b1;
    acc = !h0[3] || (tp[2] ? h0[5] : (ds ? mt : h0[4]));
    note(1, 32'({acc, good, tp}), m);
    u_peer.send(nb, good, {ft, ar, ds, mt}, pace, ts, te);
    if (acc && good && ar && l0[4]) begin
      k = (te - ts + 192000) / 320000 + 1;
      note(2, 32'(h1[7] ? ts + 149 + k * 320000 : te + 192149), 0);
    end
  endtask : frm
  task automatic drain();
    for (int j = 0; j < 6000 && q.size() > 0; j++) tick(1);
    if (q.size() > 0) begin
      err("expected result never appeared");
      tally_and_finish();
    end
  endtask : drain
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // ==========================================
  // main sequence
  initial begin
    tick(12);
    rstn = 1'b1;
    tick(1);
    rd(ADDR_MC0H, RST_MC0H);
    rd(ADDR_MC0L, RST_MC0L);
    rd(ADDR_MC1H, RST_MC1H);
    prb(5, 32'({RST_MC0L[AUTO_CHECKSUM_BIT], 5'(RST_MC0L[PRE_HI:0]) + 5'h01}));
    for (i = 0; i < 3; i++) begin
      v = 8'($random(seed));
      wr(ADDR_MC0H + 16'(i), v);
      rd(ADDR_MC0H + 16'(i), v);
    end
    wr(16'hDF05, 8'hFF);
    rd(16'hDF05, 8'h00);
    rd(16'hDF01, 8'h00);
    wr(ADDR_MC1H, RST_MC1H);
    wr(ADDR_MC0L, 8'h62);
    for (i = 0; i < 24; i++) begin
      v = 8'($random(seed));
      v[7:6] = 2'(i);
      wr(ADDR_MC0H, v);
      f = 8'($random(seed));
      frm(2 + f[7:6], 1'b1, f[5:3], f[2], f[1], f[0], 1, 32'h1F);
    end
    wr(ADDR_MC0H, RST_MC0H);
    frm(4, 1'b0, 3'h1, 1'b0, 1'b1, 1'b1, 1, 32'h08);
    wr(ADDR_MC0L, 8'h72);
    frm(3, 1'b1, 3'h1, 1'b1, 1'b1, 1'b1, 1, 32'h1F);
    drain();
    frm(3, 1'b0, 3'h1, 1'b1, 1'b1, 1'b1, 1, 32'h08);
    tick(2100);
    wr(ADDR_MC1H, 8'hB0);
    frm(4, 1'b1, 3'h1, 1'b1, 1'b1, 1'b1, 30, 32'h1F);
    drain();
    frm(4, 1'b1, 3'h1, 1'b1, 1'b1, 1'b1, 1, 32'h1F);
    drain();
    wr(ADDR_MC1H, RST_MC1H);
    fork
      frm(6, 1'b1, 3'h1, 1'b0, 1'b1, 1'b0, 4, 32'h1F);
      begin
        tick(20);
        wr(ADDR_MC0H, 8'h02);
      end
    join
    frm(2, 1'b1, 3'h1, 1'b0, 1'b1, 1'b0, 1, 32'h1F);
    drain();
    wr(ADDR_MC0L, 8'h62);
    for (i = 0; i < 8; i++) begin
      t = 8'($random(seed) % 50);
      {channel_clear_threshold_in, channel_clear_threshold_wr} = {t, 1'b1};
      tick(1);
      channel_clear_threshold_wr = 1'b0;
      wr(ADDR_MC0H, {5'h01, 3'(i)});
      rssi = t + 8'h01;
      tick(2);
      prb(3, 32'h0);
      rssi = t - 8'(i);
      tick(2);
      prb(3, 32'h0);
      rssi = t - 8'(i) - 8'h01;
      tick(2);
      prb(3, 32'h1);
    end
    // one and two byte preambles are left out on purpose
    for (i = 2; i < 16; i++) begin
      v = 8'($random(seed));
      wr(ADDR_MC0L, {v[7:4], 4'(i)});
      tx_start = 1'b1;
      tick(1);
      tx_start = 1'b0;
      c = 16'h0000;
      f = 8'($random(seed));
      repeat (8) begin
        {tx_bit, tx_bit_valid} = {f[0], 1'b1};
        c = (c >> 1) ^ ((c[0] ^ f[0]) ? 16'h8408 : 16'h0000);
        f = f >> 1;
        tick(1);
      end
      tx_bit_valid = 1'b0;
      tick(1);
      prb(5, 32'({v[5], 5'(i) + 5'h01}));
      prb(6, 32'(c));
    end
    repeat (16) begin
      v = 8'($random(seed));
      wr(ADDR_MC1H, v);
      f = 8'($random(seed));
      corr_level = f[0] ? v[4:0] : v[4:0] - 5'h01;
      corr_peak_ok = f[1];
      tick(2);
      prb(4, 32'(corr_level >= v[4:0] && (!v[5] || corr_peak_ok)));
    end
    drain();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
